// [common/xops_pkg.sv]
// Shared types and constants for the extended instruction datapath
package xops_pkg;

    typedef enum logic [2:0] {
        ext_byte_swap,
        ext_sign_extend,
        ext_zero_test,
        ext_exclusive_or,
        wide_register_add,
        wide_jump,
        wide_subroutine_call,
        wide_subroutine_return
    } op_type;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_ADDR
    } size_type;

    typedef enum logic [2:0] {
        AM_REG,
        AM_IMM,
        AM_INDIRECT,
        AM_AUTOINC,
        AM_INDEXED,
        AM_SYMBOLIC,
        AM_ABSOLUTE
    } mode_type;

    // Status word bit positions
    localparam int SR_C_POS = 0;
    localparam int SR_Z_POS = 1;
    localparam int SR_N_POS = 2;
    localparam int SR_V_POS = 8;
    localparam logic [15:0] SR_RESET = 16'h0000;

    // Address steps in bytes
    localparam logic [19:0] WORD_STEP   = 20'h00002;
    localparam logic [19:0] DWORD_STEP  = 20'h00004;
    localparam logic [19:0] BYTE_STEP   = 20'h00001;
    localparam logic [19:0] HI_OFFSET   = 20'h00002;
    localparam logic [19:0] ADDR_RESET  = 20'h00000;

    // Operand masks per width
    localparam logic [31:0] MASK_ADDR = 32'h000fffff;
    localparam logic [31:0] MASK_WORD = 32'h0000ffff;
    localparam logic [31:0] MASK_BYTE = 32'h000000ff;

endpackage : xops_pkg

// [logic/xops_alu.sv]
// Combinational result and status flag unit
`timescale 1ns/1ps
module xops_alu
    import xops_pkg::*;
(
    input  op_type      op,
    input  size_type    sz,
    input  wire logic   reg_mode,
    input  wire logic [31:0] dst,
    input  wire logic [19:0] src,
    output logic [31:0] res,
    output logic        n_flag,
    output logic        z_flag,
    output logic        c_flag,
    output logic        v_flag,
    output logic        wr,
    output logic        flg
);

    function automatic logic [31:0] width_mask(input size_type s, input logic [31:0] val);
        case (s)
            SZ_ADDR: width_mask = val & MASK_ADDR;
            SZ_BYTE: width_mask = val & MASK_BYTE;
            default: width_mask = val & MASK_WORD;
        endcase
    endfunction : width_mask

    function automatic logic msb_of(input size_type s, input logic [31:0] val);
        case (s)
            SZ_ADDR: msb_of = val[19];
            SZ_BYTE: msb_of = val[7];
            default: msb_of = val[15];
        endcase
    endfunction : msb_of

    logic [20:0] sum;
    logic [15:0] swapped;

    always_comb begin
        sum     = {1'b0, dst[19:0]} + {1'b0, src};
        swapped = {dst[7:0], dst[15:8]};
        res     = dst;
        wr      = 1'b0;
        flg     = 1'b0;
        n_flag  = 1'b0;
        z_flag  = 1'b0;
        c_flag  = 1'b0;
        v_flag  = 1'b0;
        case (op)
            ext_byte_swap: begin
                wr = 1'b1;
                if (sz == SZ_ADDR) begin
                    res = {12'h000, dst[19:16], swapped};
                end else if (reg_mode) begin
                    res = {16'h0000, swapped};
                end else begin
                    res = {dst[31:16], swapped};
                end
            end
            ext_sign_extend: begin
                wr  = 1'b1;
                flg = 1'b1;
                if (reg_mode || sz == SZ_ADDR) begin
                    res = {12'h000, {12{dst[7]}}, dst[7:0]};
                end else begin
                    res = {dst[31:16], {8{dst[7]}}, dst[7:0]};
                end
                n_flag = msb_of(sz, res);
                z_flag = (width_mask(sz, res) == 32'h00000000);
                c_flag = ~z_flag;
                v_flag = 1'b0;
            end
            ext_zero_test: begin
                flg    = 1'b1;
                n_flag = msb_of(sz, dst);
                z_flag = (width_mask(sz, dst) == 32'h00000000);
                c_flag = 1'b1;
                v_flag = 1'b0;
            end
            ext_exclusive_or: begin
                wr     = 1'b1;
                flg    = 1'b1;
                res    = width_mask(sz, dst ^ {12'h000, src});
                n_flag = msb_of(sz, res);
                z_flag = (res == 32'h00000000);
                c_flag = ~z_flag;
                v_flag = msb_of(sz, dst) & msb_of(sz, {12'h000, src});
            end
            wide_register_add: begin
                wr     = 1'b1;
                flg    = 1'b1;
                res    = {12'h000, sum[19:0]};
                n_flag = sum[19];
                z_flag = (sum[19:0] == 20'h00000);
                c_flag = sum[20];
                v_flag = (dst[19] == src[19]) && (sum[19] != dst[19]);
            end
            default: begin
                res = dst;
            end
        endcase
    end

endmodule : xops_alu

// [logic/extended_cpu_ops_datapath.sv]
// Execution datapath for extended data and address instructions
`timescale 1ns/1ps
module extended_cpu_ops_datapath
    import xops_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  op_type           op_in,
    input  size_type         size_in,
    input  mode_type         mode_in,
    input  wire logic [19:0] src_in,
    input  wire logic [19:0] dst_reg_in,
    input  wire logic [19:0] base_in,
    input  wire logic [19:0] ofs_in,
    input  wire logic [19:0] pc_in,
    input  wire logic [19:0] sp_in,
    input  wire logic [15:0] sr_in,
    input  wire logic        sr_load,
    output logic             busy,
    output logic             done,
    output logic             illegal,
    output logic             reg_we,
    output logic [19:0]      reg_wdata,
    output logic             ptr_we,
    output logic [19:0]      ptr_wdata,
    output logic             pc_we,
    output logic [19:0]      pc_wdata,
    output logic             sp_we,
    output logic [19:0]      sp_wdata,
    output logic [15:0]      sr_out,
    output logic             mem_req,
    output logic             mem_we,
    output logic [19:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_LO,
        ST_RD_HI,
        ST_EXEC,
        ST_WR_LO,
        ST_WR_HI,
        ST_PUSH_HI,
        ST_PUSH_LO,
        ST_POP_LO,
        ST_POP_HI
    } state_type;

    typedef struct packed {
        state_type   st;
        op_type      op;
        size_type    sz;
        mode_type    mode;
        logic [19:0] src;
        logic [19:0] base;
        logic [19:0] ret;
        logic [19:0] sp;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [15:0] sr;
        logic        done;
        logic        illegal;
        logic        reg_we;
        logic [19:0] reg_wd;
        logic        ptr_we;
        logic [19:0] ptr_wd;
        logic        pc_we;
        logic [19:0] pc_wd;
        logic        sp_we;
        logic [19:0] sp_wd;
        logic        mem_req;
        logic        mem_we;
        logic [19:0] mem_addr;
        logic [15:0] mem_wd;
    } regs_type;

    localparam regs_type REGS_RESET = '{
        st: ST_IDLE, op: ext_byte_swap, sz: SZ_WORD, mode: AM_REG,
        src: ADDR_RESET, base: ADDR_RESET, ret: ADDR_RESET, sp: ADDR_RESET,
        lo: 16'h0000, hi: 16'h0000, sr: SR_RESET,
        done: 1'b0, illegal: 1'b0, reg_we: 1'b0, reg_wd: ADDR_RESET,
        ptr_we: 1'b0, ptr_wd: ADDR_RESET, pc_we: 1'b0, pc_wd: ADDR_RESET,
        sp_we: 1'b0, sp_wd: ADDR_RESET, mem_req: 1'b0, mem_we: 1'b0,
        mem_addr: ADDR_RESET, mem_wd: 16'h0000
    };

    regs_type r_r;
    regs_type r_nxt;

    function automatic logic [19:0] sext16(input logic [19:0] v);
        sext16 = {{4{v[15]}}, v[15:0]};
    endfunction : sext16

    function automatic logic [19:0] step_of(input size_type s);
        case (s)
            SZ_ADDR: step_of = DWORD_STEP;
            SZ_BYTE: step_of = BYTE_STEP;
            default: step_of = WORD_STEP;
        endcase
    endfunction : step_of

    function automatic logic is_addr_op(input op_type o);
        is_addr_op = (o == wide_register_add) || (o == wide_jump) || (o == wide_subroutine_call);
    endfunction : is_addr_op

    // Effective operand address
    logic [19:0] ea;
    always_comb begin
        case (mode_in)
            AM_INDEXED:  ea = base_in + sext16(ofs_in);
            AM_SYMBOLIC: ea = pc_in + sext16(ofs_in);
            AM_ABSOLUTE: ea = ofs_in;
            default:     ea = base_in;
        endcase
    end

    logic        reg_mode;
    logic        wide_fetch;
    logic        byte_hi_lane;
    logic [31:0] alu_dst;
    logic [31:0] alu_res;
    logic        alu_n;
    logic        alu_z;
    logic        alu_c;
    logic        alu_v;
    logic        alu_wr;
    logic        alu_flg;
    logic [15:0] merged_lo;

    always_comb begin
        reg_mode     = (r_r.mode == AM_REG) || (r_r.mode == AM_IMM);
        wide_fetch   = (r_r.sz == SZ_ADDR) || (r_r.op == wide_jump) || (r_r.op == wide_subroutine_call);
        byte_hi_lane = r_r.mem_addr[0];
        if (!reg_mode && r_r.sz == SZ_BYTE) begin
            alu_dst = {24'h000000, byte_hi_lane ? r_r.lo[15:8] : r_r.lo[7:0]};
        end else begin
            alu_dst = {r_r.hi, r_r.lo};
        end
    end

    always_comb begin
        if (r_r.sz == SZ_BYTE) begin
            merged_lo = byte_hi_lane ? {alu_res[7:0], r_r.lo[7:0]} : {r_r.lo[15:8], alu_res[7:0]};
        end else begin
            merged_lo = alu_res[15:0];
        end
    end

    xops_alu u_alu (
        .op       (r_r.op),
        .sz       (r_r.sz),
        .reg_mode (reg_mode),
        .dst      (alu_dst),
        .src      (r_r.src),
        .res      (alu_res),
        .n_flag   (alu_n),
        .z_flag   (alu_z),
        .c_flag   (alu_c),
        .v_flag   (alu_v),
        .wr       (alu_wr),
        .flg      (alu_flg)
    );

    always_comb begin
        r_nxt         = r_r;
        r_nxt.done    = 1'b0;
        r_nxt.illegal = 1'b0;
        r_nxt.reg_we  = 1'b0;
        r_nxt.ptr_we  = 1'b0;
        r_nxt.pc_we   = 1'b0;
        r_nxt.sp_we   = 1'b0;
        if (sr_load && r_r.st == ST_IDLE) begin
            r_nxt.sr = sr_in;
        end
        case (r_r.st)
            ST_IDLE: begin
                if (start) begin
                    r_nxt.op   = op_in;
                    r_nxt.sz   = (is_addr_op(op_in) || op_in == wide_subroutine_return) ? SZ_ADDR : size_in;
                    r_nxt.mode = mode_in;
                    r_nxt.src  = (mode_in == AM_IMM) ? ofs_in : src_in;
                    r_nxt.base = base_in;
                    r_nxt.ret  = pc_in;
                    r_nxt.sp   = sp_in;
                    if (op_in == wide_subroutine_return) begin
                        r_nxt.mem_req  = 1'b1;
                        r_nxt.mem_we   = 1'b0;
                        r_nxt.mem_addr = sp_in;
                        r_nxt.st       = ST_POP_LO;
                    end else if (op_in == wide_register_add && mode_in != AM_REG && mode_in != AM_IMM) begin
                        r_nxt.illegal = 1'b1;
                        r_nxt.done    = 1'b1;
                    end else if (op_in == wide_register_add) begin
                        {r_nxt.hi, r_nxt.lo} = {12'h000, dst_reg_in};
                        r_nxt.st = ST_EXEC;
                    end else if (mode_in == AM_REG || mode_in == AM_IMM) begin
                        if (is_addr_op(op_in)) begin
                            {r_nxt.hi, r_nxt.lo} = {12'h000, (mode_in == AM_IMM) ? ofs_in : src_in};
                        end else begin
                            {r_nxt.hi, r_nxt.lo} = {12'h000, dst_reg_in};
                        end
                        r_nxt.st = ST_EXEC;
                    end else begin
                        r_nxt.mem_req  = 1'b1;
                        r_nxt.mem_we   = 1'b0;
                        r_nxt.mem_addr = (size_in == SZ_BYTE && !is_addr_op(op_in)) ? ea : {ea[19:1], 1'b0};
                        r_nxt.st       = ST_RD_LO;
                    end
                end
            end
            ST_RD_LO: begin
                if (mem_ack) begin
                    r_nxt.lo = mem_rdata;
                    r_nxt.hi = 16'h0000;
                    if (wide_fetch) begin
                        r_nxt.mem_addr = {r_r.mem_addr[19:1], 1'b0} + HI_OFFSET;
                        r_nxt.st       = ST_RD_HI;
                    end else begin
                        r_nxt.mem_req = 1'b0;
                        r_nxt.st      = ST_EXEC;
                    end
                end
            end
            ST_RD_HI: begin
                if (mem_ack) begin
                    r_nxt.hi       = mem_rdata;
                    r_nxt.mem_req  = 1'b0;
                    r_nxt.mem_addr = r_r.mem_addr - HI_OFFSET;
                    r_nxt.st       = ST_EXEC;
                end
            end
            ST_EXEC: begin
                r_nxt.st = ST_IDLE;
                if (r_r.mode == AM_AUTOINC) begin
                    r_nxt.ptr_we = 1'b1;
                    r_nxt.ptr_wd = r_r.base + (is_addr_op(r_r.op) ? DWORD_STEP : step_of(r_r.sz));
                end
                if (r_r.op == wide_jump) begin
                    r_nxt.pc_we = 1'b1;
                    r_nxt.pc_wd = {r_r.hi[3:0], r_r.lo};
                    r_nxt.done  = 1'b1;
                end else if (r_r.op == wide_subroutine_call) begin
                    r_nxt.pc_wd    = {r_r.hi[3:0], r_r.lo};
                    r_nxt.mem_req  = 1'b1;
                    r_nxt.mem_we   = 1'b1;
                    r_nxt.mem_addr = r_r.sp - WORD_STEP;
                    r_nxt.mem_wd   = {12'h000, r_r.ret[19:16]};
                    r_nxt.st       = ST_PUSH_HI;
                end else begin
                    if (alu_flg) begin
                        r_nxt.sr[SR_N_POS] = alu_n;
                        r_nxt.sr[SR_Z_POS] = alu_z;
                        r_nxt.sr[SR_C_POS] = alu_c;
                        r_nxt.sr[SR_V_POS] = alu_v;
                    end
                    if (alu_wr && reg_mode) begin
                        r_nxt.reg_we = 1'b1;
                        r_nxt.reg_wd = alu_res[19:0];
                        r_nxt.done   = 1'b1;
                    end else if (alu_wr) begin
                        r_nxt.mem_req  = 1'b1;
                        r_nxt.mem_we   = 1'b1;
                        r_nxt.mem_addr = (r_r.sz == SZ_BYTE) ? {r_r.mem_addr[19:1], 1'b0} : r_r.mem_addr;
                        r_nxt.mem_wd   = merged_lo;
                        r_nxt.hi       = alu_res[31:16];
                        r_nxt.st       = ST_WR_LO;
                    end else begin
                        r_nxt.done = 1'b1;
                    end
                end
            end
            ST_WR_LO: begin
                if (mem_ack) begin
                    if (r_r.sz == SZ_ADDR) begin
                        r_nxt.mem_addr = r_r.mem_addr + HI_OFFSET;
                        r_nxt.mem_wd   = r_r.hi;
                        r_nxt.st       = ST_WR_HI;
                    end else begin
                        r_nxt.mem_req = 1'b0;
                        r_nxt.mem_we  = 1'b0;
                        r_nxt.done    = 1'b1;
                        r_nxt.st      = ST_IDLE;
                    end
                end
            end
            ST_WR_HI: begin
                if (mem_ack) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.mem_we  = 1'b0;
                    r_nxt.done    = 1'b1;
                    r_nxt.st      = ST_IDLE;
                end
            end
            ST_PUSH_HI: begin
                if (mem_ack) begin
                    r_nxt.mem_addr = r_r.sp - DWORD_STEP;
                    r_nxt.mem_wd   = r_r.ret[15:0];
                    r_nxt.st       = ST_PUSH_LO;
                end
            end
            ST_PUSH_LO: begin
                if (mem_ack) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.mem_we  = 1'b0;
                    r_nxt.sp_we   = 1'b1;
                    r_nxt.sp_wd   = r_r.sp - DWORD_STEP;
                    r_nxt.pc_we   = 1'b1;
                    r_nxt.done    = 1'b1;
                    r_nxt.st      = ST_IDLE;
                end
            end
            ST_POP_LO: begin
                if (mem_ack) begin
                    r_nxt.lo       = mem_rdata;
                    r_nxt.mem_addr = r_r.sp + WORD_STEP;
                    r_nxt.st       = ST_POP_HI;
                end
            end
            ST_POP_HI: begin
                if (mem_ack) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.pc_we   = 1'b1;
                    r_nxt.pc_wd   = {mem_rdata[3:0], r_r.lo};
                    r_nxt.sp_we   = 1'b1;
                    r_nxt.sp_wd   = r_r.sp + DWORD_STEP;
                    r_nxt.done    = 1'b1;
                    r_nxt.st      = ST_IDLE;
                end
            end
            default: begin
                r_nxt = REGS_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r_r <= REGS_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Mode bits in the status word are only ever passed through
    assign sr_out    = r_r.sr;
    assign busy      = (r_r.st != ST_IDLE);
    assign done      = r_r.done;
    assign illegal   = r_r.illegal;
    assign reg_we    = r_r.reg_we;
    assign reg_wdata = r_r.reg_wd;
    assign ptr_we    = r_r.ptr_we;
    assign ptr_wdata = r_r.ptr_wd;
    assign pc_we     = r_r.pc_we;
    assign pc_wdata  = r_r.pc_wd;
    assign sp_we     = r_r.sp_we;
    assign sp_wdata  = r_r.sp_wd;
    assign mem_req   = r_r.mem_req;
    assign mem_we    = r_r.mem_we;
    assign mem_addr  = r_r.mem_addr;
    assign mem_wdata = r_r.mem_wd;

endmodule : extended_cpu_ops_datapath

// [tb/xops_mem_model.sv]
// Word-wide memory model answering the datapath memory port
`timescale 1ns/1ps
module xops_mem_model (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [19:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic [15:0]      mem_rdata,
    output logic             mem_ack
);
    logic [15:0] mem [0:1023];
    logic [1:0]  wait_r;
    // Answers at once or after two extra cycles; read data is stale-scrambled between acks
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h5a5a;
        end else if (mem_req && !mem_ack && wait_r == (slow ? 2'h2 : 2'h0)) begin
            mem_ack <= 1'b1;
            wait_r <= 2'h0;
            if (mem_we)
                mem[mem_addr[10:1]] <= mem_wdata;
            else
                mem_rdata <= mem[mem_addr[10:1]];
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack)
                wait_r <= wait_r + 2'h1;
        end
    end
endmodule : xops_mem_model

// [tb/extended_cpu_ops_datapath_monitor.sv]
// Assertion checker for the extended instruction datapath ports
`timescale 1ns/1ps
module extended_cpu_ops_datapath_monitor
    import xops_pkg::*;
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        start,
    input op_type           op_in,
    input wire logic [19:0] sp_in,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        illegal,
    input wire logic        reg_we,
    input wire logic [19:0] reg_wdata,
    input wire logic        sp_we,
    input wire logic [19:0] sp_wdata,
    input wire logic [15:0] sr_out,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [19:0] mem_addr,
    input wire logic        mem_ack
);
    op_type      op_r;
    logic [19:0] sp_r;
    // Remembers the operation and stack pointer taken with start
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            op_r <= ext_byte_swap;
            sp_r <= 20'h0;
        end else if (start && !busy) begin
            op_r <= op_in;
            sp_r <= sp_in;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sequence s_hi_push;
        mem_req && mem_we && mem_ack && op_r == wide_subroutine_call && mem_addr == sp_r - 20'h2;
    endsequence
    property p_push; s_hi_push |=> mem_req && mem_we && mem_addr == sp_r - 20'h4; endproperty
    a_push: assert property (p_push) else $error("second push address wrong");
    property p_swap; done && op_r == ext_byte_swap |-> $stable(sr_out); endproperty
    a_swap: assert property (p_swap) else $error("swap altered status");
    property p_jmp; done && op_r inside {wide_jump, wide_subroutine_return} |-> $stable(sr_out); endproperty
    a_jmp: assert property (p_jmp) else $error("jump or return altered status");
    property p_sxf; done && op_r == ext_sign_extend |-> sr_out[SR_C_POS] != sr_out[SR_Z_POS] && !sr_out[SR_V_POS];
    endproperty
    a_sxf: assert property (p_sxf) else $error("sign extend flags wrong");
    property p_tst; done && op_r == ext_zero_test |-> sr_out[SR_C_POS] && !sr_out[SR_V_POS] && !reg_we; endproperty
    a_tst: assert property (p_tst) else $error("test flags or write wrong");
    property p_sxr; reg_we && op_r == ext_sign_extend |-> reg_wdata[19:8] == {12{reg_wdata[7]}}; endproperty
    a_sxr: assert property (p_sxr) else $error("sign extend register wrong");
    property p_csp; sp_we && op_r == wide_subroutine_call |-> sp_wdata == sp_r - 20'h4 && $stable(sr_out);
    endproperty
    a_csp: assert property (p_csp) else $error("call stack use wrong");
    property p_rsp; sp_we && op_r == wide_subroutine_return |-> sp_wdata == sp_r + 20'h4; endproperty
    a_rsp: assert property (p_rsp) else $error("return stack use wrong");
    property p_ill; done && illegal |-> op_r == wide_register_add && !reg_we && !sp_we; endproperty
    a_ill: assert property (p_ill) else $error("refused add had effect");
endmodule : extended_cpu_ops_datapath_monitor
bind extended_cpu_ops_datapath extended_cpu_ops_datapath_monitor mon_u (.*);

// [tb/extended_cpu_ops_datapath_tb.sv]
// Self-checking bench for the extended instruction datapath
`timescale 1ns/1ps
module extended_cpu_ops_datapath_tb
    import xops_pkg::*;
;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        start = 1'b0;
    logic        sr_load = 1'b0;
    logic        slow = 1'b0;
    op_type      op_in = ext_byte_swap;
    size_type    size_in = SZ_ADDR;
    mode_type    mode_in = AM_REG;
    logic [19:0] src_in = 20'h0, dst_reg_in = 20'h0, base_in = 20'h0, ofs_in = 20'h0;
    logic [19:0] pc_in = 20'h12346, sp_in = 20'h00400;
    logic [15:0] sr_in = 16'h0;
    logic        busy, done, illegal, reg_we, ptr_we, pc_we, sp_we, mem_req, mem_we, mem_ack;
    logic [19:0] reg_wdata, ptr_wdata, pc_wdata, sp_wdata, mem_addr;
    logic [15:0] sr_out, mem_wdata, mem_rdata;
    logic [3:0]  seen;
    int          mismatches = 0;
    int          n_tests = 0;
    always #2.5 mclk = ~mclk;
    extended_cpu_ops_datapath dut_u (.*);
    xops_mem_model mem_u (.*);
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic put(input logic [19:0] a, input logic [15:0] v);
        mem_u.mem[a[10:1]] = v;
    endtask : put
    function automatic logic [19:0] get(input logic [19:0] a);
        return {4'h0, mem_u.mem[a[10:1]]};
    endfunction : get
    // Issues one instruction, collects write strobes, returns in the done cycle
    task automatic run(input op_type o, input size_type s, input mode_type m,
                       input logic [19:0] d, input logic [19:0] b, input logic [19:0] f);
        int k;
        @(posedge mclk);
        op_in <= o;
        size_in <= s;
        mode_in <= m;
        dst_reg_in <= d;
        base_in <= b;
        src_in <= f;
        ofs_in <= f;
        slow <= ~slow;
        start <= 1'b1;
        seen = 4'h0;
        k = 0;
        do begin
            @(posedge mclk);
            start <= 1'b0;
            #1;
            seen = seen | {reg_we, ptr_we, pc_we, sp_we};
            k++;
        end while (done !== 1'b1 && k < 60);
        chk({18'h0, busy, done}, 20'h1);
    endtask : run
    task automatic t_swap;
        run(ext_byte_swap, SZ_ADDR, AM_REG, 20'h23456, 20'h0, 20'h0);
        chk(reg_wdata, 20'h25634);
        chk({4'h0, sr_out}, 20'h00107);
        run(ext_byte_swap, SZ_WORD, AM_REG, 20'h23456, 20'h0, 20'h0);
        chk(reg_wdata, 20'h05634);
        put(20'h00100, 16'h3456);
        put(20'h00102, 16'hff02);
        run(ext_byte_swap, SZ_ADDR, AM_INDIRECT, 20'h0, 20'h00100, 20'h0);
        chk(get(20'h00100), 20'h05634);
        chk(get(20'h00102), 20'h00002);
    endtask : t_swap
    task automatic t_sxt;
        run(ext_sign_extend, SZ_ADDR, AM_REG, 20'h00080, 20'h0, 20'h0);
        chk(reg_wdata, 20'hfff80);
        chk({4'h0, sr_out}, 20'h00005);
        put(20'h00104, 16'h1280);
        run(ext_sign_extend, SZ_WORD, AM_INDIRECT, 20'h0, 20'h00104, 20'h0);
        chk(get(20'h00104), 20'h0ff80);
        put(20'h00108, 16'h0080);
        put(20'h0010a, 16'h1234);
        run(ext_sign_extend, SZ_ADDR, AM_INDIRECT, 20'h0, 20'h00108, 20'h0);
        chk(get(20'h00108), 20'h0ff80);
        chk(get(20'h0010a), 20'h0000f);
    endtask : t_sxt
    task automatic t_test;
        run(ext_zero_test, SZ_BYTE, AM_REG, 20'h12300, 20'h0, 20'h0);
        chk({4'h0, sr_out}, 20'h00003);
        chk({16'h0, seen}, 20'h0);
        run(ext_zero_test, SZ_ADDR, AM_REG, 20'h80000, 20'h0, 20'h0);
        chk({4'h0, sr_out}, 20'h00005);
    endtask : t_test
    task automatic t_xor_add;
        run(ext_exclusive_or, SZ_WORD, AM_REG, 20'h18003, 20'h0, 20'h08001);
        chk(reg_wdata, 20'h00002);
        chk({4'h0, sr_out}, 20'h00101);
        put(20'h00120, 16'h81f0);
        run(ext_exclusive_or, SZ_BYTE, AM_ABSOLUTE, 20'h0, 20'h0, 20'h00121);
        chk(get(20'h00120), 20'h0a0f0);
        chk({4'h0, sr_out}, 20'h00005);
        run(wide_register_add, SZ_ADDR, AM_REG, 20'h7ffff, 20'h0, 20'h00001);
        chk(reg_wdata, 20'h80000);
        chk({4'h0, sr_out}, 20'h00104);
        run(wide_register_add, SZ_ADDR, AM_INDIRECT, 20'h7ffff, 20'h00100, 20'h00001);
        chk({19'h0, illegal}, 20'h1);
        chk({16'h0, seen}, 20'h0);
    endtask : t_xor_add
    task automatic t_jump;
        put(20'h00110, 16'h1234);
        put(20'h00112, 16'h0005);
        run(wide_jump, SZ_ADDR, AM_AUTOINC, 20'h0, 20'h00110, 20'h0);
        chk(pc_wdata, 20'h51234);
        chk(ptr_wdata, 20'h00114);
        chk({4'h0, sr_out}, 20'h00104);
        put(20'h001f0, 16'hbeef);
        put(20'h001f2, 16'h0003);
        run(wide_jump, SZ_ADDR, AM_INDEXED, 20'h0, 20'h00200, 20'h0fff0);
        chk(pc_wdata, 20'h3beef);
        run(wide_jump, SZ_ADDR, AM_IMM, 20'h0, 20'h0, 20'h1aa04);
        chk(pc_wdata, 20'h1aa04);
    endtask : t_jump
    task automatic t_call_ret;
        run(wide_subroutine_call, SZ_ADDR, AM_IMM, 20'h0, 20'h0, 20'h4abcd);
        chk(get(20'h003fe), 20'h00001);
        chk(get(20'h003fc), 20'h02346);
        chk(pc_wdata, 20'h4abcd);
        chk(sp_wdata, 20'h003fc);
        chk({16'h0, seen}, 20'h00003);
        @(posedge mclk);
        sp_in <= 20'h003fc;
        run(wide_subroutine_return, SZ_ADDR, AM_REG, 20'h0, 20'h0, 20'h0);
        chk(pc_wdata, 20'h12346);
        chk(sp_wdata, 20'h00400);
    endtask : t_call_ret
    initial begin
        #50000;
        mismatches++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        sr_in <= 16'h0107;
        sr_load <= 1'b1;
        @(posedge mclk);
        sr_load <= 1'b0;
        t_swap();
        t_sxt();
        t_test();
        t_xor_add();
        t_jump();
        t_call_ret();
        test_done();
    end
endmodule : extended_cpu_ops_datapath_tb
